/* rtl/slcd_regs.vh */
// ============================================================
// slcd_regs.vh - register indices, fields and reset values of the
// segment lcd front end; assumes byte address = index * 4
`ifndef SLCD_REGS_VH
`define SLCD_REGS_VH
// register indices (byte address is four times the index)
`define SLCD_IDX_RAM_FIRST 16'hf740
`define SLCD_IDX_RAM_LAST 16'hf74f
`define SLCD_IDX_PORT_DUTY 16'hffc0
`define SLCD_IDX_DISP_CTRL 16'hffc1
`define SLCD_IDX_DISP_CTRL2 16'hffc2
`define SLCD_IDX_CLK_STOP2 16'hfffb
// port_and_duty_control fields
`define SLCD_DUTY_HI 7
`define SLCD_DUTY_LO 6
`define SLCD_MIRROR_BIT 5
`define SLCD_RSVD_BIT 4
`define SLCD_SGS_HI 3
`define SLCD_SGS_LO 0
// display_control fields
`define SLCD_PSW_BIT 6
`define SLCD_ACT_BIT 5
`define SLCD_DISP_BIT 4
`define SLCD_CKS_HI 3
`define SLCD_CKS_LO 0
// display_control_second fields
`define SLCD_WAVE_B_BIT 7
`define SLCD_SPLIT_CUT_BIT 6
// module_clock_stop_second: lcd standby control bit (0 = standby)
`define SLCD_LCD_CKSTP_BIT 0
// reset values
`define SLCD_RST_PORT_DUTY 8'h00
`define SLCD_RST_DISP_CTRL 8'h80
`define SLCD_RST_DISP_CTRL2 8'h00
`define SLCD_RST_CLK_STOP2 8'hff
`define SLCD_DISP_CTRL_FIXED 8'h80
// duty codes
`define SLCD_DUTY_STATIC 2'b00
`define SLCD_DUTY_HALF 2'b01
`define SLCD_DUTY_THIRD 2'b10
`define SLCD_DUTY_QUARTER 2'b11
// frame clock: highest of the eleven settings
`define SLCD_CKS_MAX 4'h0a
// axi responses
`define SLCD_RESP_OKAY 2'b00
`define SLCD_RESP_SLVERR 2'b10
`endif

/* rtl/slcd_top.v */
// ============================================================
// slcd_top.v - segment lcd duty/common select front end with an
// axi4-lite register slave; assumes one clock, synchronous reset
`timescale 1ns/1ps
`include "slcd_regs.vh"

// How it works
// RQ1 - duty field decodes static, half, third, quarter; reset gives static, mirror off
// RQ2 - static with mirror drives all four commons like common one
// RQ3 - half duty with mirror copies commons one and three onto two and four
// RQ4 - mirror acts in static and half duty only; third duty keeps common four idle
// RQ5 - software writes zero to reserved bit four; it reads back zero
// RQ6 - sixteen byte display memory at f740..f74f, not reset
// RQ7 - thirty-two segment outputs, each switchable to segment or port use
// RQ8 - panel drive stops in chip standby; it runs only with the display and active bits set and the lcd not in module standby
// RQ9 - frame frequency chosen from eleven settings
// RQ10 - waveform type a or b chosen by software
// RQ11 - software can disconnect the supply split resistors
// RQ12 - clock stop register puts lcd alone into module standby
// RQ13 - segment select enables groups of four upward, then releases upward
// RQ14 - commons are scanned slot by slot, segments from that common's bits
module slcd_top #(
  parameter SLOT_BASE = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [17:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire chip_standby,
  output reg [3:0] common_outputs,
  output reg [3:0] common_enable,
  output reg [31:0] segment_outputs,
  output reg [31:0] segment_enable,
  output reg split_resistor_cut,
  output reg lcd_power_on
);

  // ============================================================
  // functions
  // group mask of segment pins in segment use, four pins per group
  function [7:0] group_mask;
    input [3:0] code;
    reg [3:0] n;
    begin
      n = code - 4'h8;
      if (code == 4'h0) begin
        group_mask = 8'h00;
      end else if (code <= 4'h8) begin
        group_mask = ~(8'hff << code); // [RQ13]
      end else begin
        group_mask = 8'hff << n; // [RQ13]
      end
    end
  endfunction
  // word index decode of a byte address; unaligned bits ignored
  function [15:0] addr_index;
    input [17:0] addr;
    begin
      addr_index = addr[17:2];
    end
  endfunction

  // ============================================================
  // registers
  reg [7:0] port_and_duty_control;
  reg [7:0] display_control;
  reg [7:0] display_control_second;
  reg [7:0] module_clock_stop_second;
  reg [7:0] display_memory [0:15]; // no reset [RQ6]
  reg standby_meta;
  reg standby_sync;

  // chip standby pin passes two flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      standby_meta <= 1'b0;
      standby_sync <= 1'b0;
    end else begin
      standby_meta <= chip_standby;
      standby_sync <= standby_meta;
    end
  end

  // ============================================================
  // axi4-lite write channel
  reg aw_held;
  reg w_held;
  reg [17:0] aw_addr;
  reg [31:0] w_data;
  reg w_lane0;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire do_write = have_aw && have_w;
  wire [17:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire wr_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
  wire [15:0] wr_idx = addr_index(wr_addr);
  wire wr_ram = (wr_idx >= `SLCD_IDX_RAM_FIRST) && (wr_idx <= `SLCD_IDX_RAM_LAST);
  wire wr_known = wr_ram || (wr_idx == `SLCD_IDX_PORT_DUTY) ||
    (wr_idx == `SLCD_IDX_DISP_CTRL) || (wr_idx == `SLCD_IDX_DISP_CTRL2) ||
    (wr_idx == `SLCD_IDX_CLK_STOP2);
  wire wr_en = do_write && wr_lane0;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // latch address and data in either order, answer once both are in
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 18'h0_0000;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLCD_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `SLCD_RESP_OKAY : `SLCD_RESP_SLVERR;
      end else begin
        aw_held <= have_aw;
        w_held <= have_w;
        if (s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // register writes; only the low byte lane carries data
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_and_duty_control <= `SLCD_RST_PORT_DUTY; // [RQ1]
      display_control <= `SLCD_RST_DISP_CTRL;
      display_control_second <= `SLCD_RST_DISP_CTRL2;
      module_clock_stop_second <= `SLCD_RST_CLK_STOP2;
    end else if (wr_en) begin
      if (wr_idx == `SLCD_IDX_PORT_DUTY) begin
        port_and_duty_control <= wr_data[7:0];
      end
      if (wr_idx == `SLCD_IDX_DISP_CTRL) begin
        display_control <= wr_data[7:0] | `SLCD_DISP_CTRL_FIXED;
      end
      if (wr_idx == `SLCD_IDX_DISP_CTRL2) begin
        display_control_second <= wr_data[7:0]; // [RQ10] [RQ11]
      end
      if (wr_idx == `SLCD_IDX_CLK_STOP2) begin
        module_clock_stop_second <= wr_data[7:0]; // [RQ12]
      end
    end
  end

  // display memory writes
  always @(posedge aclk) begin
    if (wr_en && wr_ram) begin
      display_memory[wr_idx[3:0]] <= wr_data[7:0]; // [RQ6]
    end
  end

  // ============================================================
  // axi4-lite read channel
  wire [15:0] rd_idx = addr_index(s_axi_araddr);
  wire rd_ram = (rd_idx >= `SLCD_IDX_RAM_FIRST) && (rd_idx <= `SLCD_IDX_RAM_LAST);
  reg [7:0] rd_byte;
  reg rd_known;

  assign s_axi_arready = !s_axi_rvalid;

  // read decode
  always @* begin
    rd_byte = 8'h00;
    rd_known = 1'b1;
    if (rd_ram) begin
      rd_byte = display_memory[rd_idx[3:0]];
    end else if (rd_idx == `SLCD_IDX_PORT_DUTY) begin
      rd_byte = port_and_duty_control;
      rd_byte[`SLCD_RSVD_BIT] = 1'b0; // write-only bit reads zero [RQ5]
    end else if (rd_idx == `SLCD_IDX_DISP_CTRL) begin
      rd_byte = display_control;
    end else if (rd_idx == `SLCD_IDX_DISP_CTRL2) begin
      rd_byte = display_control_second;
    end else if (rd_idx == `SLCD_IDX_CLK_STOP2) begin
      rd_byte = module_clock_stop_second;
    end else begin
      rd_known = 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SLCD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_known ? `SLCD_RESP_OKAY : `SLCD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // field decode
  wire [1:0] duty = port_and_duty_control[`SLCD_DUTY_HI:`SLCD_DUTY_LO]; // [RQ1]
  wire mirror = port_and_duty_control[`SLCD_MIRROR_BIT];
  wire [3:0] sgs = port_and_duty_control[`SLCD_SGS_HI:`SLCD_SGS_LO];
  wire [7:0] seg_groups = group_mask(sgs); // one bit per group of four pins [RQ13]
  wire [3:0] cks_raw = display_control[`SLCD_CKS_HI:`SLCD_CKS_LO];
  wire [3:0] cks = (cks_raw > `SLCD_CKS_MAX) ? `SLCD_CKS_MAX : cks_raw; // [RQ9]
  wire wave_b = display_control_second[`SLCD_WAVE_B_BIT];
  wire lcd_module_run = module_clock_stop_second[`SLCD_LCD_CKSTP_BIT];
  wire drive_on = lcd_module_run && !standby_sync && // [RQ8] [RQ12]
    display_control[`SLCD_DISP_BIT] && display_control[`SLCD_ACT_BIT];
  wire [1:0] last_slot = duty; // slots used = duty code + 1

  // ============================================================
  // frame timing: slot length is SLOT_BASE << cks clocks
  reg [31:0] presc;
  reg [1:0] slot;
  reg polarity;
  wire [31:0] slot_len = SLOT_BASE << cks;
  wire slot_end = (presc >= slot_len - 32'h0000_0001);
  wire frame_end = slot_end && (slot >= last_slot);

  // common scan, slot by slot, polarity per slot (a) or frame (b)
  always @(posedge aclk) begin
    if (!aresetn) begin
      presc <= 32'h0000_0000;
      slot <= 2'b00;
      polarity <= 1'b0;
    end else if (!drive_on) begin
      presc <= 32'h0000_0000;
      slot <= 2'b00;
      polarity <= 1'b0;
    end else if (slot_end) begin
      presc <= 32'h0000_0000;
      slot <= frame_end ? 2'b00 : slot + 2'b01; // [RQ14]
      if (frame_end || !wave_b) begin
        polarity <= !polarity; // [RQ10]
      end
    end else begin
      presc <= presc + 32'h0000_0001;
    end
  end

  // ============================================================
  // common mapping: source slot and use of each common
  reg [7:0] com_src;
  reg [3:0] next_com_en;
  reg [3:0] next_com;
  reg [31:0] next_seg;
  integer k, j;

  always @* begin
    com_src = 8'b11_10_01_00;
    next_com_en = 4'b1111;
    case (duty)
      `SLCD_DUTY_STATIC: begin
        com_src = 8'b00_00_00_00; // [RQ2]
        next_com_en = mirror ? 4'b1111 : 4'b0001; // [RQ2]
      end
      `SLCD_DUTY_HALF: begin
        com_src = mirror ? 8'b01_01_00_00 : 8'b11_10_01_00; // [RQ3] [RQ14]
        next_com_en = mirror ? 4'b1111 : 4'b0011; // [RQ3]
      end
      `SLCD_DUTY_THIRD: begin
        next_com_en = 4'b0111; // common four stays idle [RQ4]
      end
      default: begin
        next_com_en = 4'b1111; // [RQ4]
      end
    endcase
    for (k = 0; k < 4; k = k + 1) begin
      next_com[k] = next_com_en[k] && (polarity ^ (com_src[2*k +: 2] == slot));
    end
    // segment s, common c sits in byte s/2, bit (s%2)*4+c
    for (k = 0; k < 32; k = k + 1) begin
      next_seg[k] = polarity ^ display_memory[k / 2][(k % 2) * 4 + slot]; // [RQ14]
    end
  end

  // ============================================================
  // registered pin drive; commons, segment outputs and lcd power low when the panel is off
  always @(posedge aclk) begin
    if (!aresetn) begin
      common_outputs <= 4'h0;
      common_enable <= 4'h0;
      segment_outputs <= 32'h0000_0000;
      segment_enable <= 32'h0000_0000;
      split_resistor_cut <= 1'b0;
      lcd_power_on <= 1'b0;
    end else begin
      for (j = 0; j < 32; j = j + 1) begin
        segment_enable[j] <= seg_groups[j / 4]; // [RQ7] [RQ13]
      end
      split_resistor_cut <= display_control_second[`SLCD_SPLIT_CUT_BIT]; // [RQ11]
      lcd_power_on <= display_control[`SLCD_PSW_BIT] && drive_on;
      if (drive_on) begin
        common_enable <= next_com_en; // [RQ2] [RQ3] [RQ4]
        common_outputs <= next_com;
        for (j = 0; j < 32; j = j + 1) begin
          segment_outputs[j] <= next_seg[j] && seg_groups[j / 4]; // [RQ7]
        end
      end else begin
        common_enable <= 4'h0; // [RQ8]
        common_outputs <= 4'h0;
        segment_outputs <= 32'h0000_0000;
      end
    end
  end

endmodule // slcd_top

/* bench/slcd_panel.sv */
// ==========================================
// panel model: notes which commons swing
// assumes the lcd pins of slcd_top
`timescale 1ns/1ps
module slcd_panel (
  input wire aclk,
  input wire clear,
  input wire [3:0] common_outputs,
  input wire [3:0] common_enable,
  output reg [3:0] toggled
);
  reg [3:0] last;
  // a driven common that changes level is scanned
  always @(posedge aclk) begin
    last <= common_outputs;
    toggled <= clear ? 4'h0 : toggled | ((common_outputs ^ last) & common_enable);
  end
endmodule // slcd_panel

/* bench/slcd_top_chk.sv */
// ==========================================
// checker on the slcd_top ports
// assumes aw and w are offered together
`timescale 1ns/1ps
`include "slcd_regs.vh"
module slcd_chk (
  input wire aclk,
  input wire aresetn,
  input wire [17:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire chip_standby,
  input wire [3:0] common_outputs,
  input wire [3:0] common_enable,
  input wire [31:0] segment_outputs,
  input wire [31:0] segment_enable
);
  reg [7:0] pd;
  reg [7:0] pd2;
  wire wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire on = common_enable != 4'h0;
  wire [1:0] dt = pd2[7:6];
  wire mx = pd2[5];
  // shadow of duty control, aligned with the pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      pd <= 8'h00;
      pd2 <= 8'h00;
    end else begin
      if (wt && s_axi_awaddr[17:2] == `SLCD_IDX_PORT_DUTY && s_axi_wstrb[0])
        pd <= s_axi_wdata[7:0];
      pd2 <= pd;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_static;
    on && dt == 2'b00 |-> common_enable == (mx ? 4'hf : 4'h1);
  endproperty
  a_static: assert property (p_static) else $error("static commons wrong");
  property p_smirror;
    on && dt == 2'b00 && mx |-> common_outputs == {4{common_outputs[0]}};
  endproperty
  a_smirror: assert property (p_smirror) else $error("static mirror wrong");
  property p_half;
    on && dt == 2'b01 |-> common_enable == (mx ? 4'hf : 4'h3) && (!mx ||
      common_outputs[1] == common_outputs[0] && common_outputs[3] == common_outputs[2]);
  endproperty
  a_half: assert property (p_half) else $error("half duty commons wrong");
  property p_third;
    on && dt == 2'b10 |-> common_enable == 4'h7 && !common_outputs[3];
  endproperty
  a_third: assert property (p_third) else $error("third duty commons wrong");
  property p_quarter;
    on && dt == 2'b11 |-> common_enable == 4'hf;
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter duty commons wrong");
  property p_port;
    (segment_outputs & ~segment_enable) == 32'h0;
  endproperty
  a_port: assert property (p_port) else $error("port pin drives segment");
  property p_standby;
    chip_standby [*5] |-> common_enable == 4'h0;
  endproperty
  a_standby: assert property (p_standby) else $error("drive runs in standby");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_wr;
    wt |=> s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  c_smirror: cover property (on && dt == 2'b00 && mx);
  c_hmirror: cover property (on && dt == 2'b01 && mx);
  c_standby: cover property (chip_standby [*5]);
endmodule // slcd_chk
bind slcd_top slcd_chk slcd_chk_i (.*);

/* bench/slcd_top_tb.sv */
// ==========================================
// self-checking bench for slcd_top
// assumes SLOT_BASE 1 and the panel model
`timescale 1ns/1ps
`include "slcd_regs.vh"
module slcd_top_tb;
  reg aclk, aresetn, awv, wv, br, arv, rr, sb, clr;
  reg [17:0] awa, ara;
  reg [31:0] wd;
  reg [7:0] v;
  reg [7:0] ram [0:15];
  wire awr, wr, bv, arr, rv, spl, pwr;
  wire [1:0] bresp, rresp;
  wire [31:0] rd, sego, sege;
  wire [3:0] como, come, tog;
  integer seed = 46570;
  integer n_fail = 0;
  integer n_compared = 0;
  integer i, m;
  slcd_top #(.SLOT_BASE(1)) slcd_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .chip_standby(sb), .common_outputs(como), .common_enable(come),
    .segment_outputs(sego), .segment_enable(sege),
    .split_resistor_cut(spl), .lcd_power_on(pwr));
  slcd_panel slcd_panel_i (.aclk(aclk), .clear(clr), .common_outputs(como),
    .common_enable(come), .toggled(tog));
  // commons in use per duty and mirror
  function [3:0] cen(input [7:0] p);
    case (p[7:6])
      2'b00: cen = p[5] ? 4'hf : 4'h1;
      2'b01: cen = p[5] ? 4'hf : 4'h3;
      2'b10: cen = 4'h7;
      default: cen = 4'hf;
    endcase
  endfunction
  // segment pins per group select code
  function [31:0] seg(input [3:0] c);
    integer g;
    for (g = 0; g < 8; g = g + 1)
      seg[g*4 +: 4] = (c != 0 && (c <= 8 ? g < c : g >= c - 8)) ? 4'hf : 4'h0;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("counts: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one write or read; d is the expected data on reads
  task bus(input w, input [15:0] idx, input [7:0] d, input [1:0] er);
    integer n;
    reg a, b, r, k;
    begin
      @(posedge aclk);
      awa <= {idx, 2'b00};
      ara <= {idx, 2'b00};
      wd <= {24'h0, d};
      awv <= w;
      wv <= w;
      br <= w;
      arv <= !w;
      rr <= !w;
      k = 0;
      for (n = 0; n < 50 && !k; n = n + 1) begin
        @(negedge aclk);
        a = awv & awr;
        b = wv & wr;
        r = arv & arr;
        k = w ? bv : rv;
        if (k) check(w ? bresp : rresp, er);
        if (k && !w) check(rd, {24'h0, d});
        @(posedge aclk);
        if (a) awv <= 1'b0;
        if (b) wv <= 1'b0;
        if (r) arv <= 1'b0;
        if (k) br <= 1'b0;
        if (k) rr <= 1'b0;
      end
      if (!k) begin
        n_fail = n_fail + 1;
        end_of_test;
      end
    end
  endtask
  // clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // main sequence
  initial begin
    {aresetn, awv, wv, br, arv, rr, sb} = 7'h00;
    clr = 1'b1;
    awa = 18'h0_0000;
    ara = 18'h0_0000;
    wd = 32'h0000_0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, `SLCD_IDX_PORT_DUTY, 8'h00, 2'b00);
    bus(0, `SLCD_IDX_DISP_CTRL, 8'h80, 2'b00);
    bus(0, `SLCD_IDX_CLK_STOP2, 8'hff, 2'b00);
    bus(1, `SLCD_IDX_RAM_LAST + 16'h0001, 8'h55, 2'b10);
    bus(0, `SLCD_IDX_RAM_LAST + 16'h0001, 8'h00, 2'b10);
    for (i = 0; i < 11; i = i + 1) begin
      bus(1, `SLCD_IDX_DISP_CTRL, 8'h70 | i[7:0], 2'b00);
      bus(0, `SLCD_IDX_DISP_CTRL, 8'hf0 | i[7:0], 2'b00);
    end
    bus(1, `SLCD_IDX_DISP_CTRL, 8'h70, 2'b00);
    bus(1, `SLCD_IDX_DISP_CTRL2, 8'hc0, 2'b00);
    bus(0, `SLCD_IDX_DISP_CTRL2, 8'hc0, 2'b00);
    check(spl, 1);
    bus(1, `SLCD_IDX_DISP_CTRL2, 8'h80, 2'b00);
    $display("registers done");
    for (i = 0; i < 8; i = i + 1) begin
      v = {i[2:1], i[0], 5'h08};
      bus(1, `SLCD_IDX_PORT_DUTY, v, 2'b00);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (40) @(posedge aclk);
      @(negedge aclk);
      check(come, cen(v));
      check(tog, cen(v));
      if (v[7:5] == 3'b010) check(como[1] ^ como[0], 1);
      check(pwr, 1);
    end
    $display("duty done");
    for (i = 0; i < 16; i = i + 1) begin
      m = $random(seed);
      v = {m[7:5], 1'b0, i[3:0]};
      bus(1, `SLCD_IDX_PORT_DUTY, v, 2'b00);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      check(sege, seg(v[3:0]));
      check(sego & ~sege, 0);
    end
    for (i = 0; i < 16; i = i + 1) begin
      m = $random(seed);
      ram[i] = m[7:0];
      bus(1, `SLCD_IDX_RAM_FIRST + i[15:0], ram[i], 2'b00);
    end
    for (i = 0; i < 16; i = i + 1)
      bus(0, `SLCD_IDX_RAM_FIRST + i[15:0], ram[i], 2'b00);
    $display("segments and memory done");
    @(posedge aclk);
    sb <= 1'b1;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check(come, 0);
    check(pwr, 0);
    @(posedge aclk);
    sb <= 1'b0;
    bus(1, `SLCD_IDX_CLK_STOP2, 8'hfe, 2'b00);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check(come, 0);
    bus(1, `SLCD_IDX_CLK_STOP2, 8'hff, 2'b00);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check(pwr, 1);
    $display("standby done");
    end_of_test;
  end
endmodule // slcd_top_tb
